// [ptm_pkg.sv]
// package for the page translation mmu: field layouts, sizes, operations
package ptm_pkg;

  // ************************************************************
  // address widths
  // ************************************************************
  localparam int PTM_EA_W = 32;
  localparam int PTM_TAG_W = 8;
  localparam int PTM_VA_W = PTM_TAG_W + PTM_EA_W;
  localparam int PTM_PA_W = 32;
  localparam int PTM_ZONE_W = 4;
  localparam int PTM_ENTRIES = 64;
  localparam int PTM_IDX_W = 6;

  // ************************************************************
  // page size codes, 1KB up to 16MB in steps of four
  // ************************************************************
  localparam logic [2:0] PTM_SZ_1K = 3'h0;
  localparam logic [2:0] PTM_SZ_16M = 3'h7;
  localparam int PTM_MIN_PAGE_BITS = 10;

  // ************************************************************
  // maintenance operations
  // ************************************************************
  typedef enum logic [2:0] {
    PTM_OP_NONE = 3'b000,
    PTM_OP_INV_ALL = 3'b001,
    PTM_OP_READ = 3'b010,
    PTM_OP_SEARCH = 3'b011,
    PTM_OP_SEARCH_REC = 3'b100,
    PTM_OP_SYNC = 3'b101,
    PTM_OP_WRITE = 3'b110
  } ptm_op_t;

  // ************************************************************
  // entry layout
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic [2:0] size;
    logic [PTM_TAG_W-1:0] tag;
    logic [21:0] epn;
    logic [21:0] rpn;
    logic ex;
    logic wr;
    logic [PTM_ZONE_W-1:0] zone;
    logic w;
    logic i;
    logic m;
    logic g;
    logic user_defined_attribute;
    logic e;
  } ptm_entry_t;

  localparam int PTM_ENTRY_W = $bits(ptm_entry_t);

  // memory attribute bundle delivered with each translated access
  typedef struct packed {
    logic w;
    logic i;
    logic g;
    logic user_defined_attribute;
    logic e;
  } ptm_attr_t;

  // zone field codes
  localparam logic [1:0] PTM_ZF_00 = 2'h0;
  localparam logic [1:0] PTM_ZF_11 = 2'h3;

endpackage

// [ptm_entry_mem.sv]
// entry storage for the translation buffer, with registered read port
module ptm_entry_mem
  import ptm_pkg::*;
#(
  parameter int DEPTH = PTM_ENTRIES,
  parameter int AW = PTM_IDX_W,
  parameter int DW = PTM_ENTRY_W
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [DEPTH];

  // ************************************************************
  // write and registered read
  // ************************************************************
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// [ptm_mmu.sv]
// page translation mmu: software managed buffer, protection, attributes
//
// Summary of operation
// - tag plus effective address form virtual address
// - eight page sizes, 1KB through 16MB
// - page translation only, no block/segment
// - software alone loads and replaces entries
// - no hardware table walk or format
// - no hardware reference or change history
// - invalidate, read, search, sync, write operations
// - no access, read only, read/write per page
// - zone fields override entry protection
// - deliver write-through, inhibit, guarded, user, endian
// - coherence attribute accepted but ignored
// - translation off uses storage-attribute registers
module ptm_mmu
  import ptm_pkg::*;
#(
  parameter int ENTRIES = PTM_ENTRIES
) (
  input wire logic clock,
  input wire logic rst,
  // configuration
  input wire logic [PTM_TAG_W-1:0] process_tag,
  input wire logic [31:0] zone_protection_reg,
  input wire logic instr_relocate,
  input wire logic data_relocate,
  input wire logic supervisor,
  input wire logic [31:0] sa_write_through,
  input wire logic [31:0] sa_cache_inhibit,
  input wire logic [31:0] sa_guarded,
  input wire logic [31:0] sa_user_defined_attribute,
  input wire logic [31:0] sa_little_endian,
  // instruction fetch
  input wire logic if_req,
  input wire logic [PTM_EA_W-1:0] if_ea,
  output logic if_done,
  output logic [PTM_PA_W-1:0] if_pa,
  output ptm_attr_t if_attr,
  output logic if_miss,
  output logic if_storage_exc,
  // load/store
  input wire logic ls_req,
  input wire logic ls_store,
  input wire logic [PTM_EA_W-1:0] ls_ea,
  output logic ls_done,
  output logic [PTM_PA_W-1:0] ls_pa,
  output ptm_attr_t ls_attr,
  output logic ls_miss,
  output logic ls_storage_exc,
  // maintenance
  input wire logic op_valid,
  input ptm_op_t op_code,
  input wire logic [PTM_IDX_W-1:0] op_index,
  input wire logic [PTM_EA_W-1:0] op_ea,
  input ptm_entry_t op_wdata,
  output logic op_done,
  output ptm_entry_t op_rdata,
  output logic [PTM_IDX_W-1:0] op_found_index,
  output logic op_found,
  output logic op_cr_eq
);

  // ************************************************************
  // state
  // ************************************************************
  // only page entries exist, no walker, no history bits
  typedef struct packed {
    logic [ENTRIES-1:0] vld;
    logic [ENTRIES-1:0][2:0] size;
    logic [ENTRIES-1:0][PTM_TAG_W-1:0] tag;
    logic [ENTRIES-1:0][21:0] epn;
    logic if_done;
    logic [PTM_PA_W-1:0] if_pa;
    ptm_attr_t if_attr;
    logic if_miss;
    logic if_exc;
    logic ls_done;
    logic [PTM_PA_W-1:0] ls_pa;
    ptm_attr_t ls_attr;
    logic ls_miss;
    logic ls_exc;
    logic op_done;
    logic op_rd_pend;
    logic op_rd_out;
    logic [PTM_IDX_W-1:0] fidx;
    logic found;
    logic cr_eq;
  } ptm_state_t;

  ptm_state_t st_ff;
  ptm_state_t nxt_st;

  ptm_entry_t mem_rdata;
  logic mem_we;
  logic [PTM_IDX_W-1:0] mem_raddr;

  // ************************************************************
  // helpers
  // ************************************************************
  // low-bit mask of the page offset; size code k gives 10+2k bits
  function automatic logic [31:0] ptm_off_mask(input logic [2:0] sz);
    logic [5:0] bits;
    bits = 6'(PTM_MIN_PAGE_BITS) + {2'h0, sz, 1'b0};
    ptm_off_mask = (32'h1 << bits) - 32'h1;
  endfunction

  // match of tag+address against one entry; tag zero matches any process
  function automatic logic ptm_hit(input logic v, input logic [2:0] sz,
                                   input logic [PTM_TAG_W-1:0] et,
                                   input logic [21:0] ep,
                                   input logic [PTM_TAG_W-1:0] pt,
                                   input logic [31:0] ea);
    logic [31:0] m;
    m = ~ptm_off_mask(sz);
    ptm_hit = v && ((et == '0) || (et == pt)) && (({ep, 10'h0} & m) == (ea & m));
  endfunction

  // lowest matching index; software must avoid overlapping entries
  function automatic logic [PTM_IDX_W:0] ptm_lookup(input ptm_state_t s,
                                                    input logic [PTM_TAG_W-1:0] pt,
                                                    input logic [31:0] ea);
    ptm_lookup = '0;
    for (int k = ENTRIES - 1; k >= 0; k--) begin
      if (ptm_hit(s.vld[k], s.size[k], s.tag[k], s.epn[k], pt, ea)) begin
        ptm_lookup = {1'b1, PTM_IDX_W'(k)};
      end
    end
  endfunction

  // storage-attribute register bit for the 128MB region of an address
  function automatic logic ptm_region(input logic [31:0] r, input logic [31:0] ea);
    ptm_region = r[5'd31 - ea[31:27]];
  endfunction

  // side entry copy used by the translate path (rpn, protection, attributes)
  ptm_entry_t side [ENTRIES];
  logic [PTM_IDX_W:0] if_lk;
  logic [PTM_IDX_W:0] ls_lk;
  logic [PTM_IDX_W:0] op_lk;
  ptm_entry_t if_ent;
  ptm_entry_t ls_ent;

  assign mem_we = op_valid && (op_code == PTM_OP_WRITE);
  assign mem_raddr = op_index;

  // ************************************************************
  // side copy of payload fields for single-cycle translation
  // ************************************************************
  always_ff @(posedge clock) begin
    if (mem_we) begin
      side[op_index] <= op_wdata;
    end
  end

  assign if_lk = ptm_lookup(st_ff, process_tag, if_ea);
  assign ls_lk = ptm_lookup(st_ff, process_tag, ls_ea);
  assign op_lk = ptm_lookup(st_ff, process_tag, op_ea);
  assign if_ent = side[if_lk[PTM_IDX_W-1:0]];
  assign ls_ent = side[ls_lk[PTM_IDX_W-1:0]];

  // effective access rights: {allow_read, allow_write, allow_exec}
  function automatic logic [2:0] ptm_rights(input ptm_entry_t en, input logic [31:0] zone_reg,
                                            input logic sup);
    logic [1:0] zf;
    zf = zone_reg[5'd31 - {en.zone, 1'b0} -: 2];
    ptm_rights = {1'b1, en.wr, en.ex};
    if (zf == PTM_ZF_00) begin
      ptm_rights = sup ? {1'b1, en.wr, en.ex} : 3'h0;
    end else if (zf == PTM_ZF_11) begin
      ptm_rights = 3'h7;
    end else if (zf == 2'h2 && sup) begin
      ptm_rights = 3'h7;
    end
  endfunction

  // attributes from an entry; m is deliberately dropped
  function automatic ptm_attr_t ptm_ent_attr(input ptm_entry_t en);
    ptm_ent_attr = '{w: en.w, i: en.i, g: en.g,
                     user_defined_attribute: en.user_defined_attribute, e: en.e};
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [2:0] rt;
    rt = '0;
    nxt_st = st_ff;
    nxt_st.if_done = if_req;
    nxt_st.ls_done = ls_req;
    nxt_st.if_miss = 1'b0;
    nxt_st.ls_miss = 1'b0;
    nxt_st.if_exc = 1'b0;
    nxt_st.ls_exc = 1'b0;
    nxt_st.op_done = 1'b0;
    nxt_st.op_rd_pend = 1'b0;
    nxt_st.op_rd_out = st_ff.op_rd_pend;  // read data stands with its op_done
    // instruction path
    if (if_req) begin
      if (!instr_relocate) begin
        nxt_st.if_pa = if_ea;
        nxt_st.if_attr = '{w: ptm_region(sa_write_through, if_ea),
                           i: ptm_region(sa_cache_inhibit, if_ea),
                           g: ptm_region(sa_guarded, if_ea),
                           user_defined_attribute: ptm_region(sa_user_defined_attribute, if_ea),
                           e: ptm_region(sa_little_endian, if_ea)};
      end else if (!if_lk[PTM_IDX_W]) begin
        nxt_st.if_miss = 1'b1;
        nxt_st.if_pa = '0;
        nxt_st.if_attr = '0;
      end else begin
        rt = ptm_rights(if_ent, zone_protection_reg, supervisor);
        nxt_st.if_exc = !rt[0];
        nxt_st.if_pa = rt[0] ? (({if_ent.rpn, 10'h0} & ~ptm_off_mask(if_ent.size))
                       | (if_ea & ptm_off_mask(if_ent.size))) : '0;
        nxt_st.if_attr = rt[0] ? ptm_ent_attr(if_ent) : '0;
      end
    end
    // load/store path
    if (ls_req) begin
      if (!data_relocate) begin
        nxt_st.ls_pa = ls_ea;
        nxt_st.ls_attr = '{w: ptm_region(sa_write_through, ls_ea),
                           i: ptm_region(sa_cache_inhibit, ls_ea),
                           g: ptm_region(sa_guarded, ls_ea),
                           user_defined_attribute: ptm_region(sa_user_defined_attribute, ls_ea),
                           e: ptm_region(sa_little_endian, ls_ea)};
      end else if (!ls_lk[PTM_IDX_W]) begin
        nxt_st.ls_miss = 1'b1;
        nxt_st.ls_pa = '0;
        nxt_st.ls_attr = '0;
      end else begin
        rt = ptm_rights(ls_ent, zone_protection_reg, supervisor);
        nxt_st.ls_exc = ls_store ? !rt[1] : !rt[2];
        nxt_st.ls_pa = nxt_st.ls_exc ? '0 :
                       (({ls_ent.rpn, 10'h0} & ~ptm_off_mask(ls_ent.size))
                       | (ls_ea & ptm_off_mask(ls_ent.size)));
        nxt_st.ls_attr = nxt_st.ls_exc ? '0 : ptm_ent_attr(ls_ent);
      end
    end
    // maintenance operations
    if (op_valid) begin
      case (op_code)
        PTM_OP_INV_ALL: begin
          nxt_st.vld = '0;
          nxt_st.op_done = 1'b1;
        end
        PTM_OP_READ: begin
          nxt_st.op_rd_pend = 1'b1;  // memory answers one cycle later
        end
        PTM_OP_SEARCH, PTM_OP_SEARCH_REC: begin
          nxt_st.found = op_lk[PTM_IDX_W];
          nxt_st.fidx = op_lk[PTM_IDX_W-1:0];
          nxt_st.cr_eq = (op_code == PTM_OP_SEARCH_REC) ? op_lk[PTM_IDX_W] : st_ff.cr_eq;
          nxt_st.op_done = 1'b1;
        end
        PTM_OP_SYNC: begin
          nxt_st.op_done = 1'b1;  // nothing outstanding in a single-cycle update
        end
        PTM_OP_WRITE: begin
          nxt_st.vld[op_index] = op_wdata.valid;
          nxt_st.size[op_index] = op_wdata.size;
          nxt_st.tag[op_index] = op_wdata.tag;
          nxt_st.epn[op_index] = op_wdata.epn;
          nxt_st.op_done = 1'b1;
        end
        default: begin
          nxt_st.op_done = 1'b1;
        end
      endcase
    end
    if (st_ff.op_rd_pend) begin
      nxt_st.op_done = 1'b1;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // entry memory, read for the read operation
  // ************************************************************
  ptm_entry_mem #(
    .DEPTH(ENTRIES),
    .AW(PTM_IDX_W),
    .DW(PTM_ENTRY_W)
  ) u_mem (
    .clock(clock),
    .wr_en(mem_we),
    .wr_addr(op_index),
    .wr_data(op_wdata),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata)
  );

  // read data carries the live valid bit so invalidate-all shows;
  // memory reads again on the second edge and valid is read live, so op_index must hold three cycles
  always_comb begin
    op_rdata = mem_rdata;
    op_rdata.valid = st_ff.vld[mem_raddr] & st_ff.op_rd_out;
    if (!st_ff.op_rd_out) begin
      op_rdata = '0;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign if_done = st_ff.if_done;
  assign if_pa = st_ff.if_pa;
  assign if_attr = st_ff.if_attr;
  assign if_miss = st_ff.if_miss;
  assign if_storage_exc = st_ff.if_exc;
  assign ls_done = st_ff.ls_done;
  assign ls_pa = st_ff.ls_pa;
  assign ls_attr = st_ff.ls_attr;
  assign ls_miss = st_ff.ls_miss;
  assign ls_storage_exc = st_ff.ls_exc;
  assign op_done = st_ff.op_done;
  assign op_found_index = st_ff.fidx;
  assign op_found = st_ff.found;
  assign op_cr_eq = st_ff.cr_eq;

endmodule

// [ptm_core_model.sv]
// core-side model: launches fetch and load/store translate requests
module ptm_core_model (
  input wire logic clock,
  output logic if_req,
  output logic [31:0] if_ea,
  output logic ls_req,
  output logic ls_store,
  output logic [31:0] ls_ea
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet pipeline at time zero
  initial begin
    if_req = 1'b0;
    ls_req = 1'b0;
    ls_store = 1'b0;
    if_ea = 32'h0;
    ls_ea = 32'h0;
  end
  // one request per call; calls back to back give one request every cycle
  task automatic xlate(input bit dp, input bit st, input logic [31:0] ea);
    @(negedge clock);
    if_req = !dp;
    ls_req = dp;
    ls_store = st;
    if (dp) begin
      ls_ea = ea;
    end else begin
      if_ea = ea;
    end
  endtask
  // released address lines show junk so a stale value can never pass
  task automatic idle();
    @(negedge clock);
    if_req = 1'b0;
    ls_req = 1'b0;
    if_ea = ~if_ea;
    ls_ea = ~ls_ea;
  endtask
endmodule

// [ptm_mmu_sva.sv]
// assertions on the ports of the page translation mmu
module ptm_mmu_sva
  import ptm_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic instr_relocate,
  input wire logic data_relocate,
  input wire logic if_req,
  input wire logic [PTM_EA_W-1:0] if_ea,
  input wire logic if_done,
  input wire logic [PTM_PA_W-1:0] if_pa,
  input ptm_attr_t if_attr,
  input wire logic if_miss,
  input wire logic ls_req,
  input wire logic [PTM_EA_W-1:0] ls_ea,
  input wire logic ls_done,
  input wire logic [PTM_PA_W-1:0] ls_pa,
  input ptm_attr_t ls_attr,
  input wire logic ls_storage_exc,
  input wire logic op_valid,
  input ptm_op_t op_code,
  input wire logic op_done,
  input ptm_entry_t op_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ****
  // translate timing and suppression
  // ****
  AST_IF_LATENCY: assert property (if_req |=> if_done)
    else $error("fetch translate not answered next cycle");
  AST_IF_NO_SPURIOUS: assert property (if_done |-> $past(if_req))
    else $error("fetch done without request");
  AST_LS_LATENCY: assert property (ls_req |=> ls_done)
    else $error("data translate not answered next cycle");
  AST_IF_REAL: assert property (if_req && !instr_relocate |=>
    if_pa == $past(if_ea) && !if_miss)
    else $error("fetch address altered with translation off");
  AST_LS_REAL: assert property (ls_req && !data_relocate |=> ls_pa == $past(ls_ea))
    else $error("data address altered with translation off");
  AST_MISS_SUPPRESS: assert property (if_miss |-> if_pa == '0 && if_attr == '0)
    else $error("miss still carries an address");
  AST_EXC_SUPPRESS: assert property (ls_storage_exc |-> ls_pa == '0 && ls_attr == '0)
    else $error("refused access still carries an address");
  AST_PA_HOLD: assert property (!if_req |=> $stable(if_pa))
    else $error("fetch address moved without request");
  // ****
  // maintenance
  // ****
  AST_OP_DONE: assert property (op_valid && op_code != PTM_OP_READ |=> op_done)
    else $error("maintenance op not done next cycle");
  AST_READ_DONE: assert property (op_valid && op_code == PTM_OP_READ |-> ##2 op_done)
    else $error("entry read not done two cycles on");
  AST_RDATA_QUIET: assert property (!op_done |-> op_rdata == '0)
    else $error("read data shown outside done");
  // main scenarios reached
  cover property (if_done && if_miss);
  cover property (ls_done && ls_storage_exc);
  cover property (op_valid && op_code == PTM_OP_WRITE);
endmodule
bind ptm_mmu ptm_mmu_sva ptm_mmu_sva_inst (.clock, .rst, .instr_relocate, .data_relocate,
  .if_req, .if_ea, .if_done, .if_pa, .if_attr, .if_miss, .ls_req, .ls_ea, .ls_done, .ls_pa,
  .ls_attr, .ls_storage_exc, .op_valid, .op_code, .op_done, .op_rdata);

// [ptm_mmu_tb.sv]
// self-checking testbench for the page translation mmu
module ptm_mmu_tb
  import ptm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] process_tag;
  logic [31:0] zone_protection_reg, sa_write_through, sa_cache_inhibit, sa_guarded;
  logic [31:0] sa_user_defined_attribute, sa_little_endian, if_ea, ls_ea, op_ea, if_pa, ls_pa;
  logic instr_relocate, data_relocate, supervisor, if_req, ls_req, ls_store, op_valid;
  logic if_done, if_miss, if_storage_exc, ls_done, ls_miss, ls_storage_exc, op_done;
  logic op_found, op_cr_eq;
  logic [5:0] op_index, op_found_index;
  ptm_attr_t if_attr, ls_attr;
  ptm_op_t op_code;
  ptm_entry_t op_wdata, op_rdata, ent;
  logic [38:0] ifq[$], lsq[$];
  logic [5:0] prot[8] = '{6'h11, 6'h12, 6'h15, 6'h34, 6'h03, 6'h0D, 6'h2C, 6'h22};
  int err_count = 0;
  int n_checks = 0;
  always #2.5 clock = ~clock;
  ptm_mmu ptm_mmu_inst (.clock, .rst, .process_tag, .zone_protection_reg, .instr_relocate,
    .data_relocate, .supervisor, .sa_write_through, .sa_cache_inhibit, .sa_guarded,
    .sa_user_defined_attribute, .sa_little_endian, .if_req, .if_ea, .if_done, .if_pa,
    .if_attr, .if_miss, .if_storage_exc, .ls_req, .ls_store, .ls_ea, .ls_done, .ls_pa,
    .ls_attr, .ls_miss, .ls_storage_exc, .op_valid, .op_code, .op_index, .op_ea, .op_wdata,
    .op_done, .op_rdata, .op_found_index, .op_found, .op_cr_eq);
  ptm_core_model ptm_core_model_inst (.clock, .if_req, .if_ea, .ls_req, .ls_store, .ls_ea);
  // ****
  // helpers
  // ****
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // note first, then launch, so the monitor never finds an empty queue
  task automatic xl(input bit dp, input bit st, input logic [31:0] ea, input logic [38:0] e);
    if (dp) lsq.push_back(e);
    else ifq.push_back(e);
    ptm_core_model_inst.xlate(dp, st, ea);
  endtask
  // maintenance op; the pipeline idles first so no translate overlaps
  task automatic op(input ptm_op_t c, input logic [5:0] ix, input logic [31:0] ea);
    ptm_core_model_inst.idle();
    op_valid = 1'b1;
    op_code = c;
    op_index = ix;
    op_ea = ea;
    op_wdata = ent;
    @(negedge clock);
    op_valid = 1'b0;
    @(negedge clock);
  endtask
  function automatic logic [31:0] xpa(int k, logic [21:0] rpn, logic [31:0] ea);
    logic [31:0] m;
    m = (32'h1 << (10 + 2 * k)) - 32'h1;
    return ({rpn, 10'h0} & ~m) | (ea & m);
  endfunction
  // compare each finished translate against the oldest note of its path
  always @(negedge clock) begin
    if (if_done === 1'b1) chk({if_pa, if_attr, if_miss, if_storage_exc}, ifq.pop_front());
    if (ls_done === 1'b1) chk({ls_pa, ls_attr, ls_miss, ls_storage_exc}, lsq.pop_front());
  end
  // watchdog: the whole run is about a hundred cycles
  initial begin
    #50000;
    err_count++;
    close_out();
  end
  // ****
  // main sequence
  // ****
  initial begin
    logic [31:0] ea, m;
    logic [21:0] rpn;
    logic [4:0] a;
    logic [5:0] c;
    int b;
    void'($urandom(6));
    {process_tag, zone_protection_reg} = {8'h5A, 32'h1000_0000};
    {instr_relocate, data_relocate, supervisor, op_valid} = 4'h0;
    {sa_write_through, sa_cache_inhibit, sa_guarded} = {$urandom(), $urandom(), $urandom()};
    {sa_user_defined_attribute, sa_little_endian} = {$urandom(), $urandom()};
    op_code = PTM_OP_NONE;
    {op_index, op_ea, op_wdata, ent} = '0;
    repeat (6) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    // translation off: straight address, attributes from the sa registers
    for (int n = 0; n < 8; n++) begin
      ea = $urandom();
      b = 31 - int'(ea[31:27]);
      a = {sa_write_through[b], sa_cache_inhibit[b], sa_guarded[b],
        sa_user_defined_attribute[b], sa_little_endian[b]};
      xl(n[0], n[1], ea, {ea, a, 2'b00});
    end
    ptm_core_model_inst.idle();
    {instr_relocate, data_relocate} = 2'b11;
    // one page per size, each probed at its first and last byte, and a ninth 1KB page left unprobed
    for (int k = 0; k < 9; k++) begin
      ea = {k[3:0], 28'($urandom())};
      rpn = 22'($urandom());
      a = 5'($urandom());
      m = (32'h1 << (10 + 2 * k[2:0])) - 32'h1;
      ent = {1'b1, k[2:0], process_tag, ea[31:10], rpn, (k < 8) ? 6'h31 : 6'h02,
        a[4:3], 1'($urandom()), a[2:0]};
      op(PTM_OP_WRITE, 6'(k), ea);
      if (k < 8) begin
        xl(1'b0, 1'b0, ea & ~m, {xpa(k, rpn, ea & ~m), a, 2'b00});
        xl(1'b1, 1'b1, ea | m, {xpa(k, rpn, ea | m), a, 2'b00});
      end
    end
    // last entry: no execute, no write, zone 2; zone field and privilege vary
    for (int n = 0; n < 8; n++) begin
      c = prot[n];
      ptm_core_model_inst.idle();
      {zone_protection_reg[27:26], supervisor} = c[5:3];
      xl(c[2:1] != 2'b00, c[2:1] == 2'b10, ea,
        c[0] ? 39'h1 : {xpa(0, rpn, ea), a, 2'b00});
    end
    ptm_core_model_inst.idle();
    process_tag = 8'hA5;
    xl(1'b0, 1'b0, ea, 39'h2);
    xl(1'b1, 1'b0, ea, 39'h2);
    ptm_core_model_inst.idle();
    process_tag = 8'h5A;
    op(PTM_OP_READ, 6'h8, 32'h0);
    chk({op_done, op_rdata}, {1'b1, ent});
    op(PTM_OP_SEARCH_REC, 6'h0, ea);
    chk({op_found, op_found_index, op_cr_eq}, {1'b1, 6'h8, 1'b1});
    op(PTM_OP_SEARCH, 6'h0, 32'hF000_0000);
    chk({op_found, op_cr_eq}, 2'b01);
    op(PTM_OP_SYNC, 6'h0, 32'h0);
    op(PTM_OP_NONE, 6'h0, 32'h0);
    op(ptm_op_t'(3'h7), 6'h0, 32'h0);
    xl(1'b1, 1'b0, ea, {xpa(0, rpn, ea), a, 2'b00});
    op(PTM_OP_INV_ALL, 6'h0, 32'h0);
    xl(1'b0, 1'b0, ea, 39'h2);
    op(PTM_OP_READ, 6'h8, 32'h0);
    chk({op_done, op_rdata.valid}, 2'b10);
    repeat (3) @(negedge clock);
    chk(ifq.size() + lsq.size(), 0);
    close_out();
  end
endmodule
